// ### hdio_pkg.sv
package hdio_pkg;
    // flow-control modes
    typedef enum logic [2:0] {
        HDIO_MODE_STATIC1 = 3'h1,
        HDIO_MODE_STATIC2 = 3'h2,
        HDIO_MODE_STROBE3 = 3'h3,
        HDIO_MODE_STROBE4 = 3'h4,
        HDIO_MODE_FULL5 = 3'h5
    } hdio_mode_t;
    // access widths
    typedef enum logic [1:0] {
        HDIO_W_BIT = 2'h0,
        HDIO_W_BYTE = 2'h1,
        HDIO_W_WORD = 2'h2,
        HDIO_W_LONG = 2'h3
    } hdio_width_t;
    localparam int HDIO_DATA_W = 32;
    localparam int HDIO_NBYTES = 4;
    localparam int HDIO_BIT_IDX_W = 5;
    localparam logic [HDIO_NBYTES-1:0] HDIO_DIR_RST = 4'h0;
    localparam logic [HDIO_DATA_W-1:0] HDIO_DATA_RST = 32'h0000_0000;
    localparam logic HDIO_POL_RST = 1'b0;
    localparam logic [HDIO_NBYTES-1:0] HDIO_MASK_BIT_BYTE = 4'h1;
    localparam logic [HDIO_NBYTES-1:0] HDIO_MASK_WORD = 4'h3;
    localparam logic [HDIO_NBYTES-1:0] HDIO_MASK_LONG = 4'hF;
endpackage

// ### hdio_sync.sv
`timescale 1ns/1ps
`default_nettype none
// two-stage synchroniser for pin inputs
module hdio_sync #(
    parameter int W = 1
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_ff;
    logic [W-1:0] q_ff;
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= '0;
            q_ff <= '0;
        end else begin
            meta_ff <= d;
            q_ff <= meta_ff;
        end
    end
    assign q = q_ff;
endmodule
`default_nettype wire

// ### hdio_port.sv
`timescale 1ns/1ps
`default_nettype none
module hdio_port
    import hdio_pkg::*;
(
    // clock and reset
    input wire logic SYS_CLK,
    input wire logic ARST_N,
    // configuration
    input wire logic CFG_WE,
    input wire logic [2:0] CFG_MODE,
    input wire logic CFG_CTL_POL,
    input wire logic CFG_FLG_POL,
    input wire logic CFG_DIR_POL,
    input wire logic [HDIO_DATA_W-1:0] CFG_DATA_POL,
    input wire logic MODULE_PORT_RESET_COMMAND,
    // access request
    input wire logic REQ_VALID,
    output logic REQ_READY,
    input wire logic REQ_WRITE,
    input wire logic [1:0] REQ_WIDTH,
    input wire logic [1:0] REQ_LANE,
    input wire logic [HDIO_BIT_IDX_W-1:0] REQ_BIT,
    input wire logic [HDIO_DATA_W-1:0] REQ_WDATA,
    // access answer
    output logic RSP_VALID,
    output logic [HDIO_DATA_W-1:0] RSP_RDATA,
    // peripheral pins
    input wire logic [HDIO_DATA_W-1:0] DATA_IN,
    output logic [HDIO_DATA_W-1:0] DATA_OUT,
    output logic [HDIO_DATA_W-1:0] DATA_OE,
    output logic PERIPHERAL_CONTROL_LINE,
    input wire logic PERIPHERAL_FLAG_LINE,
    output logic IO_DIRECTION_LINE,
    // status
    output logic [HDIO_NBYTES-1:0] LANE_IS_OUTPUT
);
    // ********************
    // functions
    // ********************
    function automatic logic [HDIO_NBYTES-1:0] lane_mask(input logic [1:0] w,
                                                          input logic [1:0] lane);
        logic [HDIO_NBYTES-1:0] m;
        m = HDIO_MASK_BIT_BYTE;
        case (w)
            HDIO_W_WORD: m = HDIO_MASK_WORD;
            HDIO_W_LONG: m = HDIO_MASK_LONG;
            default: m = HDIO_MASK_BIT_BYTE;
        endcase
        lane_mask = m << lane;
    endfunction

    function automatic logic [HDIO_DATA_W-1:0] expand(input logic [HDIO_NBYTES-1:0] m);
        logic [HDIO_DATA_W-1:0] e;
        e = '0;
        for (int i = 0; i < HDIO_NBYTES; i++) begin
            e[i*8 +: 8] = {8{m[i]}};
        end
        expand = e;
    endfunction

    // ********************
    // pin synchronisers
    // ********************
    logic [HDIO_DATA_W-1:0] din_s;
    logic flag_s;
    hdio_sync #(.W(HDIO_DATA_W+1)) u_sync (
        .clk(SYS_CLK),
        .arst_n(ARST_N),
        .d({PERIPHERAL_FLAG_LINE, DATA_IN}),
        .q({flag_s, din_s})
    );

    // ********************
    // state
    // ********************
    typedef enum {ST_IDLE, ST_SETUP, ST_WAIT_FLAG, ST_WAIT_DROP, ST_DONE} hdio_state_t;
    hdio_state_t st_ff, nxt_st;
    hdio_mode_t mode_ff, nxt_mode;
    logic ctl_pol_ff, nxt_ctl_pol, flg_pol_ff, nxt_flg_pol, dir_pol_ff, nxt_dir_pol;
    logic [HDIO_DATA_W-1:0] dpol_ff, nxt_dpol;
    logic [HDIO_NBYTES-1:0] dir_ff, nxt_dir;
    logic [HDIO_DATA_W-1:0] out_ff, nxt_out;
    logic [HDIO_DATA_W-1:0] rdata_ff, nxt_rdata;
    logic rvalid_ff, nxt_rvalid, ctl_ff, nxt_ctl, iodir_ff, nxt_iodir;
    logic wr_ff, nxt_wr;
    logic [1:0] width_ff, nxt_width, lane_ff, nxt_lane;
    logic [HDIO_BIT_IDX_W-1:0] bit_ff, nxt_bit;

    logic flag_act;
    logic [HDIO_DATA_W-1:0] din_pol, rd_raw, wmask;
    logic [HDIO_NBYTES-1:0] amask;
    assign flag_act = flag_s ^ flg_pol_ff;
    assign din_pol = din_s ^ dpol_ff;
    assign amask = lane_mask(width_ff, lane_ff);

    always_comb begin
        nxt_st = st_ff;
        nxt_mode = mode_ff;
        nxt_ctl_pol = ctl_pol_ff;
        nxt_flg_pol = flg_pol_ff;
        nxt_dir_pol = dir_pol_ff;
        nxt_dpol = dpol_ff;
        nxt_dir = dir_ff;
        nxt_out = out_ff;
        nxt_rdata = rdata_ff;
        nxt_rvalid = 1'b0;
        nxt_ctl = 1'b0;
        nxt_iodir = iodir_ff;
        nxt_wr = wr_ff;
        nxt_width = width_ff;
        nxt_lane = lane_ff;
        nxt_bit = bit_ff;
        rd_raw = din_pol >> ({3'h0, lane_ff} * 8);
        wmask = '0;
        if (CFG_WE && st_ff == ST_IDLE) begin
            nxt_mode = hdio_mode_t'(CFG_MODE);
            nxt_ctl_pol = CFG_CTL_POL;
            nxt_flg_pol = CFG_FLG_POL;
            nxt_dir_pol = CFG_DIR_POL;
            nxt_dpol = CFG_DATA_POL;
        end
        if (MODULE_PORT_RESET_COMMAND) begin
            nxt_dir = HDIO_DIR_RST;
        end
        case (st_ff)
            ST_IDLE: begin
                if (REQ_VALID && !MODULE_PORT_RESET_COMMAND) begin
                    nxt_wr = REQ_WRITE;
                    nxt_width = REQ_WIDTH;
                    nxt_lane = (REQ_WIDTH == HDIO_W_BIT) ? REQ_BIT[4:3] : REQ_LANE;
                    nxt_bit = REQ_BIT;
                    nxt_iodir = REQ_WRITE;
                    if (REQ_WRITE) begin
                        // whole byte lanes switch together
                        nxt_dir = dir_ff | lane_mask(REQ_WIDTH, nxt_lane);
                        wmask = (REQ_WIDTH == HDIO_W_BIT) ?
                                (HDIO_DATA_W'(1) << REQ_BIT) :
                                expand(lane_mask(REQ_WIDTH, REQ_LANE));
                        // signed values are stored as two's complement bits
                        nxt_out = (out_ff & ~wmask) |
                                  ((REQ_WDATA << ({3'h0, REQ_LANE} * 8)) & wmask);
                        if (REQ_WIDTH == HDIO_W_BIT) begin
                            nxt_out = (out_ff & ~wmask) |
                                      ({HDIO_DATA_W{REQ_WDATA[0]}} & wmask);
                        end
                    end else if (mode_ff != HDIO_MODE_STATIC2) begin
                        nxt_dir = dir_ff & ~lane_mask(REQ_WIDTH, nxt_lane);
                    end
                    nxt_st = ST_SETUP;
                end
            end
            ST_SETUP: begin
                // one cycle for data/direction to settle before the strobe
                if (mode_ff == HDIO_MODE_FULL5) begin
                    nxt_ctl = 1'b1;
                    nxt_st = ST_WAIT_FLAG;
                end else begin
                    nxt_st = ST_DONE;
                end
            end
            ST_WAIT_FLAG: begin
                nxt_ctl = 1'b1;
                if (flag_act) begin
                    nxt_ctl = 1'b0;
                    nxt_st = ST_WAIT_DROP;
                end
            end
            ST_WAIT_DROP: begin
                if (!flag_act) begin
                    nxt_st = ST_DONE;
                end
            end
            ST_DONE: begin
                nxt_rvalid = 1'b1;
                if (!wr_ff) begin
                    case (width_ff)
                        HDIO_W_BIT: nxt_rdata = {31'h0, din_pol[bit_ff]};
                        HDIO_W_BYTE: nxt_rdata = {24'h0, rd_raw[7:0]};
                        HDIO_W_WORD: nxt_rdata = {{16{rd_raw[15]}}, rd_raw[15:0]};
                        default: nxt_rdata = din_pol;
                    endcase
                end else begin
                    nxt_rdata = '0;
                end
                nxt_st = ST_IDLE;
            end
            default: nxt_st = ST_IDLE;
        endcase
    end

    always_ff @(posedge SYS_CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            st_ff <= ST_IDLE;
            mode_ff <= HDIO_MODE_STATIC1;
            ctl_pol_ff <= HDIO_POL_RST;
            flg_pol_ff <= HDIO_POL_RST;
            dir_pol_ff <= HDIO_POL_RST;
            dpol_ff <= '0;
            dir_ff <= HDIO_DIR_RST;
            out_ff <= HDIO_DATA_RST;
            rdata_ff <= HDIO_DATA_RST;
            rvalid_ff <= 1'b0;
            ctl_ff <= 1'b0;
            iodir_ff <= 1'b0;
            wr_ff <= 1'b0;
            width_ff <= HDIO_W_BIT;
            lane_ff <= 2'h0;
            bit_ff <= '0;
        end else begin
            st_ff <= nxt_st;
            mode_ff <= nxt_mode;
            ctl_pol_ff <= nxt_ctl_pol;
            flg_pol_ff <= nxt_flg_pol;
            dir_pol_ff <= nxt_dir_pol;
            dpol_ff <= nxt_dpol;
            dir_ff <= nxt_dir;
            out_ff <= nxt_out;
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            ctl_ff <= nxt_ctl;
            iodir_ff <= nxt_iodir;
            wr_ff <= nxt_wr;
            width_ff <= nxt_width;
            lane_ff <= nxt_lane;
            bit_ff <= nxt_bit;
        end
    end

    // ********************
    // outputs
    // ********************
    assign REQ_READY = (st_ff == ST_IDLE) && !MODULE_PORT_RESET_COMMAND;
    assign RSP_VALID = rvalid_ff;
    assign RSP_RDATA = rdata_ff;
    assign DATA_OUT = out_ff ^ dpol_ff;
    assign DATA_OE = expand(dir_ff);
    assign PERIPHERAL_CONTROL_LINE = ctl_ff ^ ctl_pol_ff;
    assign IO_DIRECTION_LINE = iodir_ff ^ dir_pol_ff;
    assign LANE_IS_OUTPUT = dir_ff;

    // ********************
    // assertions
    // ********************
    sequence ctl_rise_s;
        $rose(ctl_ff);
    endsequence
    sequence flag_seen_s;
        st_ff == ST_WAIT_FLAG && flag_act;
    endsequence

    full_mode_only_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ctl_ff |-> mode_ff == HDIO_MODE_FULL5)
        else $error("control asserted outside full handshake");
    ctl_hold_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ctl_ff && st_ff == ST_WAIT_FLAG && !flag_act |=> ctl_ff)
        else $error("control dropped before flag");
    ctl_release_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        flag_seen_s |=> !ctl_ff)
        else $error("control held after flag");
    write_valid_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ctl_rise_s and wr_ff |-> (dir_ff & amask) == amask)
        else $error("strobe without driven data");
    read_release_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        ctl_rise_s and !wr_ff and mode_ff == HDIO_MODE_FULL5 |-> (dir_ff & amask) == '0)
        else $error("ready while still driving");
    port_reset_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        MODULE_PORT_RESET_COMMAND |=> dir_ff == HDIO_DIR_RST)
        else $error("lanes not input after port reset");
    bit_read_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        rvalid_ff && !wr_ff && width_ff == HDIO_W_BIT |-> rdata_ff[31:1] == '0)
        else $error("bit read out of range");
    byte_range_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        rvalid_ff && width_ff == HDIO_W_BYTE |-> rdata_ff[31:8] == '0)
        else $error("byte read out of range");
    word_sign_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        rvalid_ff && !wr_ff && width_ff == HDIO_W_WORD |-> rdata_ff[31:16] == {16{rdata_ff[15]}})
        else $error("word not sign extended");
    dir_line_a: assert property (@(posedge SYS_CLK) disable iff (!ARST_N)
        st_ff == ST_SETUP |-> iodir_ff == wr_ff)
        else $error("direction line wrong");
endmodule
`default_nettype wire

// ### hdio_periph_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// peripheral on the handshake lines
// ****************************************
module hdio_periph_model (
    // clock
    input wire logic clk,
    // handshake
    input wire logic ctl,
    input wire logic [3:0] lat,
    output logic flag
);
    logic [3:0] cnt;
    initial begin
        flag = 1'b0;
        cnt = 4'h0;
    end
    // flag follows the control line lat+1 cycles after it changes
    always @(posedge clk) begin
        if (ctl !== flag) begin
            if (cnt >= lat) begin
                flag <= ctl;
                cnt <= 4'h0;
            end else begin
                cnt <= cnt + 4'h1;
            end
        end else begin
            cnt <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// ### hdio_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module hdio_port_tb;
    import hdio_pkg::*;
    logic SYS_CLK = 1'b0, ARST_N = 1'b0, CFG_WE = 1'b0, MODULE_PORT_RESET_COMMAND = 1'b0;
    logic [2:0] CFG_MODE = 3'h1;
    logic REQ_VALID = 1'b0, REQ_READY, REQ_WRITE = 1'b0, RSP_VALID;
    logic [1:0] REQ_WIDTH = 2'h0, REQ_LANE = 2'h0;
    logic [4:0] REQ_BIT = 5'h00;
    logic [31:0] REQ_WDATA = 32'h0, RSP_RDATA, DATA_IN, DATA_OUT, DATA_OE, rd_value = 32'h0;
    logic PERIPHERAL_CONTROL_LINE, PERIPHERAL_FLAG_LINE, IO_DIRECTION_LINE;
    logic [3:0] LANE_IS_OUTPUT, lat = 4'h1;
    logic [31:0] exp_q[$], wexp = 32'h0;
    logic cur_wr = 1'b0;
    int err_count = 0, compares = 0, rsp_cnt = 0, seed = 32'h3e28d0b1, ctl_rises = 0;
    always #4 SYS_CLK = ~SYS_CLK;
    // pins: driven lanes carry the port, released lanes the peripheral
    assign DATA_IN = (DATA_OE & DATA_OUT) | (~DATA_OE & rd_value);
    hdio_port dut_u (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .CFG_WE(CFG_WE), .CFG_MODE(CFG_MODE),
        .CFG_CTL_POL(1'b0), .CFG_FLG_POL(1'b0), .CFG_DIR_POL(1'b0), .CFG_DATA_POL(32'h0),
        .MODULE_PORT_RESET_COMMAND(MODULE_PORT_RESET_COMMAND), .REQ_VALID(REQ_VALID),
        .REQ_READY(REQ_READY), .REQ_WRITE(REQ_WRITE), .REQ_WIDTH(REQ_WIDTH),
        .REQ_LANE(REQ_LANE), .REQ_BIT(REQ_BIT), .REQ_WDATA(REQ_WDATA), .RSP_VALID(RSP_VALID),
        .RSP_RDATA(RSP_RDATA), .DATA_IN(DATA_IN), .DATA_OUT(DATA_OUT), .DATA_OE(DATA_OE),
        .PERIPHERAL_CONTROL_LINE(PERIPHERAL_CONTROL_LINE),
        .PERIPHERAL_FLAG_LINE(PERIPHERAL_FLAG_LINE), .IO_DIRECTION_LINE(IO_DIRECTION_LINE),
        .LANE_IS_OUTPUT(LANE_IS_OUTPUT));
    hdio_periph_model periph_u (.clk(SYS_CLK), .ctl(PERIPHERAL_CONTROL_LINE), .lat(lat),
        .flag(PERIPHERAL_FLAG_LINE));
    // ****************************************
    // compare tasks and verdict
    // ****************************************
    task automatic cmp_val(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize;
        $display("counts: compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    // ****************************************
    // answer monitor
    // ****************************************
    always @(negedge SYS_CLK) begin
        if (RSP_VALID === 1'b1) begin
            if (exp_q.size() == 0) begin
                cmp_val("unexpected answer", 32'h0, 32'h1);
            end else begin
                cmp_val("read data", exp_q.pop_front(), RSP_RDATA);
            end
            rsp_cnt++;
        end
    end
    // mode 5: control rises with data valid or with the port ready
    always @(posedge PERIPHERAL_CONTROL_LINE) begin
        ctl_rises++;
        cmp_val("direction at ctl", {31'h0, cur_wr}, {31'h0, IO_DIRECTION_LINE});
        if (cur_wr) begin
            cmp_val("data at ctl", wexp, DATA_OUT);
        end else begin
            cmp_val("oe at ctl", 32'h0, DATA_OE);
        end
    end
    // control drops only after the flag answered
    always @(negedge PERIPHERAL_CONTROL_LINE) begin
        if (ARST_N === 1'b1) begin
            cmp_val("flag at ctl drop", 32'h1, {31'h0, PERIPHERAL_FLAG_LINE});
        end
    end
    // ****************************************
    // drivers
    // ****************************************
    task automatic access(input logic wr, input logic [1:0] wd, input logic [1:0] ln,
                          input logic [4:0] b, input logic [31:0] wd_val, input logic [31:0] exp);
        int n;
        int start;
        n = 0;
        start = rsp_cnt;
        exp_q.push_back(exp);
        @(negedge SYS_CLK);
        cur_wr = wr;
        REQ_VALID = 1'b1;
        REQ_WRITE = wr;
        REQ_WIDTH = wd;
        REQ_LANE = ln;
        REQ_BIT = b;
        REQ_WDATA = wd_val;
        while (REQ_READY !== 1'b1 && n < 100) begin
            @(negedge SYS_CLK);
            n++;
        end
        @(negedge SYS_CLK);
        REQ_VALID = 1'b0;
        while (rsp_cnt == start && n < 500) begin
            @(negedge SYS_CLK);
            n++;
        end
        if (n >= 500) begin
            cmp_val("answer timeout", 32'h0, 32'h1);
        end
    endtask
    task automatic set_mode(input logic [2:0] m);
        @(negedge SYS_CLK);
        CFG_MODE = m;
        CFG_WE = 1'b1;
        @(negedge SYS_CLK);
        CFG_WE = 1'b0;
    endtask
    // ****************************************
    // tests
    // ****************************************
    initial begin
        repeat (10) @(negedge SYS_CLK);
        ARST_N = 1'b1;
        cmp_val("lanes after reset", 32'h0, {28'h0, LANE_IS_OUTPUT});
        cmp_val("oe after reset", 32'h0, DATA_OE);
        cmp_val("ctl after reset", 32'h0, {31'h0, PERIPHERAL_CONTROL_LINE});
        $display("test reset done");
        for (int i = 0; i < 6; i++) begin
            @(negedge SYS_CLK);
            rd_value = $random(seed);
            access(1'b0, 2'h0, 2'h0, 5'(i * 5), 32'h0, {31'h0, rd_value[i * 5]});
            access(1'b0, 2'h1, 2'(i), 5'h0, 32'h0, {24'h0, rd_value[8 * (i % 4) +: 8]});
            access(1'b0, 2'h2, 2'h0, 5'h0, 32'h0, {{16{rd_value[15]}}, rd_value[15:0]});
            access(1'b0, 2'h3, 2'h0, 5'h0, 32'h0, rd_value);
        end
        cmp_val("dir line read", 32'h0, {31'h0, IO_DIRECTION_LINE});
        $display("test static reads done");
        access(1'b1, 2'h1, 2'h2, 5'h0, 32'h0000_00A5, 32'h0);
        cmp_val("byte lanes", 32'h4, {28'h0, LANE_IS_OUTPUT});
        cmp_val("byte oe", 32'h00FF_0000, DATA_OE);
        cmp_val("byte out", 32'hA5, {24'h0, DATA_OUT[23:16]});
        cmp_val("dir line write", 32'h1, {31'h0, IO_DIRECTION_LINE});
        access(1'b1, 2'h2, 2'h0, 5'h0, 32'h0000_8001, 32'h0);
        cmp_val("word out", 32'h8001, {16'h0, DATA_OUT[15:0]});
        access(1'b1, 2'h0, 2'h0, 5'd25, 32'h1, 32'h0);
        cmp_val("bit out", 32'h1, {31'h0, DATA_OUT[25]});
        cmp_val("bit lanes", 32'hF, {28'h0, LANE_IS_OUTPUT[3:1], LANE_IS_OUTPUT[0]});
        cmp_val("bit oe", 32'hFFFF_FFFF, DATA_OE);
        set_mode(3'h2);
        access(1'b0, 2'h3, 2'h0, 5'h0, 32'h0, 32'h02A5_8001);
        cmp_val("lanes after mode 2 read", 32'hF, {28'h0, LANE_IS_OUTPUT});
        set_mode(3'h1);
        @(negedge SYS_CLK);
        MODULE_PORT_RESET_COMMAND = 1'b1;
        @(negedge SYS_CLK);
        MODULE_PORT_RESET_COMMAND = 1'b0;
        cmp_val("lanes after port reset", 32'h0, {28'h0, LANE_IS_OUTPUT});
        $display("test static writes done");
        set_mode(3'h5);
        for (int i = 0; i < 4; i++) begin
            @(negedge SYS_CLK);
            lat = 4'($unsigned($random(seed)) % 4) + 4'h1;
            wexp = $random(seed);
            access(1'b1, 2'h3, 2'h0, 5'h0, wexp, 32'h0);
            rd_value = $random(seed);
            access(1'b0, 2'h3, 2'h0, 5'h0, 32'h0, rd_value);
        end
        cmp_val("handshakes", 32'h8, ctl_rises);
        $display("test handshake done");
        wexp = 32'h1234_5678;
        access(1'b1, 2'h3, 2'h0, 5'h0, wexp, 32'h0);
        @(negedge SYS_CLK);
        ARST_N = 1'b0;
        @(negedge SYS_CLK);
        ARST_N = 1'b1;
        cmp_val("lanes after mid reset", 32'h0, {28'h0, LANE_IS_OUTPUT});
        cur_wr = 1'b0;
        rd_value = 32'h0000_00FF;
        access(1'b0, 2'h1, 2'h0, 5'h0, 32'h0, 32'hFF);
        cmp_val("ctl rises after reset", 32'h9, ctl_rises);
        $display("test second reset done");
        summarize();
    end
    initial begin
        #400000;
        err_count++;
        summarize();
    end
endmodule
`default_nettype wire
